/* icu_consts.svh */
`ifndef ICU_CONSTS_SVH
`define ICU_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define ICU_IDX_ENABLE_MASK     16'h4302
`define ICU_IDX_CONTROL         16'h4304
`define ICU_IDX_LEVEL_SETUP     16'h4306
`define ICU_IDX_STATUS          16'h43F0

// Number of sources and width of one priority level.
`define ICU_NUM_SRC             16
`define ICU_LVL_W               3

// Controller control fields.
`define ICU_CTL_GEN_BIT         0
`define ICU_CTL_WMASK           16'h0001
`define ICU_CTL_RESET           1'b0

// Port level setup fields.
`define ICU_LVL_P1_TRIG_BIT     12
`define ICU_LVL_P1_LVL_LSB      8
`define ICU_LVL_P0_TRIG_BIT     4
`define ICU_LVL_P0_LVL_LSB      0
`define ICU_LVL_WMASK           16'h1717
`define ICU_LVL_RESET           16'h0000

// Enable mask fields.
`define ICU_EN_WMASK            16'hFFFF
`define ICU_EN_RESET            16'h0000

// Status fields.
`define ICU_STA_FLAG_LSB        0
`define ICU_STA_REQ_BIT         4
`define ICU_STA_VEC_LSB         8
`define ICU_STA_LVL_LSB         12

`endif

/* icu_pkg.sv */
package icu_pkg;

    typedef enum logic {
        ICU_TRIG_PULSE = 1'b0,
        ICU_TRIG_LEVEL = 1'b1
    } icu_trig_t;

    typedef logic [2:0]        icu_level_t;
    typedef logic [3:0]        icu_vec_t;
    typedef logic [15:0]       icu_src_vec_t;
    typedef logic [13:0][2:0]  icu_ext_levels_t;
    typedef logic [15:0][2:0]  icu_all_levels_t;

endpackage : icu_pkg

/* icu_req_if.sv */
`timescale 1ns/1ps

interface icu_req_if;
    import icu_pkg::*;

    icu_src_vec_t    pending;
    icu_all_levels_t levels;
    logic            req;
    icu_vec_t        vec;
    icu_level_t      lvl;

    modport producer (
        output pending,
        output levels,
        input  req,
        input  vec,
        input  lvl
    );

    modport resolver (
        input  pending,
        input  levels,
        output req,
        output vec,
        output lvl
    );

endinterface : icu_req_if

/* icu_port_trig.sv */
`timescale 1ns/1ps

module icu_port_trig (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Trigger modes and source lines.
    input  wire logic [1:0] i_mode,
    input  wire logic [1:0] i_src,
    input  wire logic [1:0] i_clr,
    // Flags.
    output logic      [1:0] o_flag
);
    import icu_pkg::*;

    logic [1:0] flag_q;
    logic [1:0] flag_d;

    always_comb begin
        for (int k = 0; k < 2; k++) begin
            if (icu_trig_t'(i_mode[k]) == ICU_TRIG_LEVEL) begin
                // The flag follows the sampled line; a clear has no effect.
                flag_d[k] = i_src[k];
            end else begin
                // A high sample sets the flag, which then holds until cleared.
                // A high sample in the clear cycle keeps the flag set.
                flag_d[k] = i_src[k] | (flag_q[k] & ~i_clr[k]);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_q <= 2'h0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_flag = flag_q;

endmodule : icu_port_trig

/* icu_prio.sv */
`timescale 1ns/1ps
`include "icu_consts.svh"

module icu_prio (
    // Clock and reset.
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    // Requests in, winner out.
    icu_req_if.resolver bus
);
    import icu_pkg::*;

    logic       req_q;
    logic       req_d;
    icu_vec_t   vec_q;
    icu_vec_t   vec_d;
    icu_level_t lvl_q;
    icu_level_t lvl_d;

    // Strictly greater wins, so on equal levels the lowest index stays chosen.
    always_comb begin
        req_d = 1'b0;
        vec_d = 4'h0;
        lvl_d = 3'h0;
        for (int i = 0; i < `ICU_NUM_SRC; i++) begin
            if (bus.pending[i] && (!req_d || bus.levels[i] > lvl_d)) begin
                req_d = 1'b1;
                vec_d = 4'(i);
                lvl_d = bus.levels[i];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q <= 1'b0;
            vec_q <= 4'h0;
            lvl_q <= 3'h0;
        end else begin
            req_q <= req_d;
            vec_q <= vec_d;
            lvl_q <= lvl_d;
        end
    end

    assign bus.req = req_q;
    assign bus.vec = vec_q;
    assign bus.lvl = lvl_q;

endmodule : icu_prio

/* icu_top.sv */
// Overview of operation
// - Each source requests only while its enable bit is 1; enables reset to 0.
// - Enable bits 8 to 15 gate the timers, serial, remote, SPI and I2C sources.
// - Enable bits 0 to 7 gate ports, timers, supply detector, LCD and PWM sources.
// - Control bit 0 permits all interrupt generation when 1; resets to 0.
// - Level setup bit 12 picks port 1 trigger: 1 level, 0 pulse at reset.
// - Level setup bit 4 picks port 0 trigger: 1 level, 0 pulse at reset.
// - Level setup holds port 1 level at bits 10-8, port 0 at 2-0.
// - Pulse mode: a sampled high sets the flag and holds it until cleared.
// - Level mode: the flag copies the sampled line; writing 1 cannot clear it.
// - Highest level enabled request wins; ties go to the lowest vector.
`timescale 1ns/1ps
`include "icu_consts.svh"

module icu_top (
    // Clock and reset.
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rstn,
    // APB slave.
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [31:0]               i_paddr,
    input  wire logic [31:0]               i_pwdata,
    input  wire logic [3:0]                i_pstrb,
    output logic      [31:0]               o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    // Interrupt sources.
    input  wire icu_pkg::icu_src_vec_t     i_src_req,
    input  wire icu_pkg::icu_ext_levels_t  i_ext_level,
    input  wire logic [1:0]                i_port_flag_clr,
    // Port flags.
    output logic      [1:0]                o_port_flag,
    // Request to the core.
    output logic                           o_irq_req,
    output icu_pkg::icu_vec_t              o_irq_vec,
    output icu_pkg::icu_level_t            o_irq_level
);
    import icu_pkg::*;

    // True when the byte address hits the word of the given register index.
    function automatic logic addr_is(input logic [31:0] addr, input logic [15:0] idx);
        return addr == {14'h0000, idx, 2'b00};
    endfunction : addr_is

    // Merges the low two byte lanes of a write into a register value.
    function automatic logic [15:0] wr_merge(input logic [15:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb,
                                             input logic [15:0] wmask);
        logic [15:0] lanes;
        logic [15:0] nv;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        nv    = (wdata[15:0] & lanes) | (old_val & ~lanes);
        return nv & wmask;
    endfunction : wr_merge

    // Reset release through two flip-flops.
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Register state.
    icu_src_vec_t en_mask_q;
    icu_src_vec_t en_mask_d;
    logic         gen_en_q;
    logic         gen_en_d;
    logic [15:0]  lvl_setup_q;
    logic [15:0]  lvl_setup_d;
    logic [15:0]  ctl_wr;
    logic [31:0]  prdata_q;
    logic [31:0]  prdata_d;

    // Bus decode.
    logic         hit_en;
    logic         hit_ctl;
    logic         hit_lvl;
    logic         hit_sta;
    logic         hit_any;
    logic         setup_rd;
    logic         access_wr;
    logic [15:0]  rd_word;
    logic [15:0]  status_word;

    // Source side.
    logic [1:0]   port_flag;
    logic [1:0]   port_mode;
    icu_level_t   p0_level;
    icu_level_t   p1_level;
    icu_src_vec_t src_pending;
    icu_src_vec_t src_gated;

    icu_req_if req_bus ();

    assign hit_en    = addr_is(i_paddr, `ICU_IDX_ENABLE_MASK);
    assign hit_ctl   = addr_is(i_paddr, `ICU_IDX_CONTROL);
    assign hit_lvl   = addr_is(i_paddr, `ICU_IDX_LEVEL_SETUP);
    assign hit_sta   = addr_is(i_paddr, `ICU_IDX_STATUS);
    assign hit_any   = hit_en | hit_ctl | hit_lvl | hit_sta;
    assign setup_rd  = i_psel & ~i_penable & ~i_pwrite;
    assign access_wr = i_psel & i_penable & i_pwrite;

    // Every access completes in its first access cycle.
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit_any;

    // Status shows the live port flags and the forwarded request.
    always_comb begin
        status_word = 16'h0000;
        status_word[`ICU_STA_FLAG_LSB +: 2] = port_flag;
        status_word[`ICU_STA_REQ_BIT]       = req_bus.req;
        status_word[`ICU_STA_VEC_LSB +: 4]  = req_bus.vec;
        status_word[`ICU_STA_LVL_LSB +: 3]  = req_bus.lvl;
    end

    // Read data is captured in the setup cycle; reserved bits read zero.
    always_comb begin
        rd_word = 16'h0000;
        if (hit_en) begin
            rd_word = en_mask_q;
        end else if (hit_ctl) begin
            rd_word[`ICU_CTL_GEN_BIT] = gen_en_q;
        end else if (hit_lvl) begin
            rd_word = lvl_setup_q;
        end else if (hit_sta) begin
            rd_word = status_word;
        end
        prdata_d = setup_rd ? {16'h0000, rd_word} : prdata_q;
    end

    // Writes take effect at the access edge; status is read only.
    always_comb begin
        en_mask_d   = en_mask_q;
        gen_en_d    = gen_en_q;
        lvl_setup_d = lvl_setup_q;
        ctl_wr      = wr_merge({15'h0000, gen_en_q}, i_pwdata, i_pstrb, `ICU_CTL_WMASK);
        if (access_wr && hit_en) begin
            en_mask_d = wr_merge(en_mask_q, i_pwdata, i_pstrb, `ICU_EN_WMASK);
        end
        if (access_wr && hit_ctl) begin
            gen_en_d = ctl_wr[`ICU_CTL_GEN_BIT];
        end
        if (access_wr && hit_lvl) begin
            lvl_setup_d = wr_merge(lvl_setup_q, i_pwdata, i_pstrb, `ICU_LVL_WMASK);
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            en_mask_q   <= `ICU_EN_RESET;
            gen_en_q    <= `ICU_CTL_RESET;
            lvl_setup_q <= `ICU_LVL_RESET;
            prdata_q    <= 32'h0000_0000;
        end else begin
            en_mask_q   <= en_mask_d;
            gen_en_q    <= gen_en_d;
            lvl_setup_q <= lvl_setup_d;
            prdata_q    <= prdata_d;
        end
    end

    assign o_prdata = prdata_q;

    // Port trigger modes and levels from the setup register.
    assign port_mode[1] = lvl_setup_q[`ICU_LVL_P1_TRIG_BIT];
    assign port_mode[0] = lvl_setup_q[`ICU_LVL_P0_TRIG_BIT];
    assign p1_level     = lvl_setup_q[`ICU_LVL_P1_LVL_LSB +: `ICU_LVL_W];
    assign p0_level     = lvl_setup_q[`ICU_LVL_P0_LVL_LSB +: `ICU_LVL_W];

    icu_port_trig u_port_trig (
        .i_clk   (i_core_clk),
        .i_rst_n (rst_n_q),
        .i_mode  (port_mode),
        .i_src   (i_src_req[1:0]),
        .i_clr   (i_port_flag_clr),
        .o_flag  (port_flag)
    );

    assign o_port_flag = port_flag;

    // Bits 0 and 1 are the port flags; bits 2 to 15 take the peripheral lines.
    assign src_pending = {i_src_req[15:8], i_src_req[7:2], port_flag};

    // Nothing reaches the resolver until the controller is enabled.
    assign src_gated = src_pending & en_mask_q & {16{gen_en_q}};

    assign req_bus.pending = src_gated;
    assign req_bus.levels  = {i_ext_level, p1_level, p0_level};

    icu_prio u_prio (
        .i_clk   (i_core_clk),
        .i_rst_n (rst_n_q),
        .bus     (req_bus.resolver)
    );

    assign o_irq_req   = req_bus.req;
    assign o_irq_vec   = req_bus.vec;
    assign o_irq_level = req_bus.lvl;

endmodule : icu_top

/* icu_top_props.sv */
`timescale 1ns/1ps

module icu_top_props (
    // Clock, reset and bus.
    input wire logic                     i_core_clk,
    input wire logic                     i_rstn,
    input wire logic                     i_psel,
    input wire logic                     i_penable,
    input wire logic [31:0]              i_paddr,
    input wire logic [31:0]              o_prdata,
    input wire logic                     o_pready,
    input wire logic                     o_pslverr,
    // Sources and request.
    input wire icu_pkg::icu_src_vec_t    i_src_req,
    input wire icu_pkg::icu_ext_levels_t i_ext_level,
    input wire logic [1:0]               o_port_flag,
    input wire logic                     o_irq_req,
    input wire icu_pkg::icu_vec_t        o_irq_vec,
    input wire icu_pkg::icu_level_t      o_irq_level
);
    import icu_pkg::*;
    icu_src_vec_t    src_q;
    icu_ext_levels_t ext_q;
    logic [1:0]      flg_q;
    logic            hit;
    assign hit = i_paddr inside {32'h00010C08, 32'h00010C10, 32'h00010C18, 32'h00010FC0};
    always_ff @(posedge i_core_clk) begin
        src_q <= i_src_req;
        ext_q <= i_ext_level;
        flg_q <= o_port_flag;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_access;
        i_psel && i_penable;
    endsequence
    a_ready_high: assert property (o_pready) else $error("pready low");
    a_err_unmapped: assert property (s_access |-> o_pslverr == !hit) else $error("pslverr wrong");
    a_rdata_upper: assert property (o_prdata[31:16] == 16'h0000) else $error("prdata upper set");
    a_irq_line: assert property (o_irq_req && o_irq_vec > 4'h1 |-> src_q[o_irq_vec])
        else $error("request without line");
    a_irq_flag: assert property (o_irq_req && o_irq_vec < 4'h2 |-> flg_q[o_irq_vec[0]])
        else $error("request without flag");
    a_irq_level: assert property (o_irq_req && o_irq_vec > 4'h1 |-> o_irq_level == ext_q[o_irq_vec - 4'h2])
        else $error("level wrong");
    a_idle_no_req: assert property (src_q == 16'h0000 && flg_q == 2'h0 |-> !o_irq_req)
        else $error("request while idle");
    a_flag_rise: assert property ((o_port_flag & ~flg_q & ~src_q[1:0]) == 2'h0)
        else $error("flag set without line");
    a_flag_fall: assert property ((~o_port_flag & flg_q & src_q[1:0]) == 2'h0)
        else $error("flag cleared while line high");
endmodule : icu_top_props

bind icu_top icu_top_props u_props (.i_core_clk, .i_rstn, .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready,
    .o_pslverr, .i_src_req, .i_ext_level, .o_port_flag, .o_irq_req, .o_irq_vec, .o_irq_level);

/* icu_src_model.sv */
`timescale 1ns/1ps

module icu_src_model (
    // Clock and wanted lines.
    input  wire logic        i_clk,
    input  wire logic [15:0] i_want,
    // Lines to the controller.
    output logic      [15:0] o_src
);
    // A source holds its line until the bench drops it, as level mode needs.
    always_ff @(posedge i_clk) begin
        o_src <= i_want;
    end
endmodule : icu_src_model

/* tb_interrupt_enable_and_level_setup.sv */
`timescale 1ns/1ps

module tb_interrupt_enable_and_level_setup;
    import icu_pkg::*;
    localparam logic [31:0] A_EN = 32'h00010C08;
    localparam logic [31:0] A_CT = 32'h00010C10;
    localparam logic [31:0] A_LV = 32'h00010C18;
    logic            clk = 1'b0;
    logic            rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [31:0]     paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic            pready, pslverr, irq, err;
    logic [1:0]      clr = 2'h0, flag;
    logic [3:0]      strb = 4'hF;
    icu_src_vec_t    want = 16'h0000, src;
    icu_ext_levels_t ext = {14{3'h0}};
    icu_vec_t        vec;
    icu_level_t      lvl;
    int              errors = 0, total_checks = 0;
    always #4 clk = ~clk;
    icu_src_model src_u (.i_clk(clk), .i_want(want), .o_src(src));
    icu_top dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_src_req(src), .i_ext_level(ext), .i_port_flag_clr(clr),
        .o_port_flag(flag), .o_irq_req(irq), .o_irq_vec(vec), .o_irq_level(lvl));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task complete_run();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task apb(input logic w, input logic [31:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            errors++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        chk(nm, rd, exp);
    endtask : rdchk
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task t_regs();
        rdchk("enable reset", A_EN, 32'h0);
        rdchk("control reset", A_CT, 32'h0);
        rdchk("level reset", A_LV, 32'h0);
        apb(1'b1, A_EN, 16'hFFFF);
        rdchk("enable rw", A_EN, 32'h0000FFFF);
        strb <= 4'h2;
        apb(1'b1, A_EN, 16'h0000);
        strb <= 4'hF;
        rdchk("enable lane", A_EN, 32'h000000FF);
        apb(1'b1, A_CT, 16'h0001);
        rdchk("control rw", A_CT, 32'h00000001);
        apb(1'b1, A_LV, 16'h1717);
        rdchk("level rw", A_LV, 32'h00001717);
        rdchk("unmapped data", 32'h00010C0C, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'b1, A_LV, 16'h0000);
        $display("register test done");
    endtask : t_regs
    task t_gate();
        int n;
        apb(1'b1, A_CT, 16'h0000);
        apb(1'b1, A_EN, 16'h0020);
        @(posedge clk);
        want <= 16'hFFFC;
        tick(4);
        chk("irq global off", 32'(irq), 32'h0);
        apb(1'b1, A_CT, 16'h0001);
        for (n = 2; n < 16; n++) begin
            apb(1'b1, A_EN, 16'(1 << n));
            tick(2);
            chk("irq gated", 32'(irq), 32'h1);
            chk("vec gated", 32'(vec), 32'(n));
        end
        apb(1'b1, A_EN, 16'h1200);
        @(posedge clk);
        ext[7] <= 3'h3;
        ext[10] <= 3'h5;
        tick(3);
        chk("vec higher", 32'(vec), 32'hC);
        chk("lvl higher", 32'(lvl), 32'h5);
        @(posedge clk);
        ext[7] <= 3'h5;
        tick(3);
        chk("vec tie", 32'(vec), 32'h9);
        apb(1'b1, A_EN, 16'h0000);
        tick(2);
        chk("irq disabled", 32'(irq), 32'h0);
        want <= 16'h0000;
        $display("gating test done");
    endtask : t_gate
    task t_port();
        apb(1'b1, A_EN, 16'h0003);
        @(posedge clk);
        want <= 16'h0001;
        @(posedge clk);
        want <= 16'h0000;
        tick(5);
        chk("pulse flag held", 32'(flag), 32'h1);
        chk("pulse vec", 32'(vec), 32'h0);
        chk("pulse irq", 32'(irq), 32'h1);
        @(posedge clk);
        clr <= 2'h1;
        @(posedge clk);
        clr <= 2'h0;
        tick(2);
        chk("pulse flag cleared", 32'(flag), 32'h0);
        apb(1'b1, A_LV, 16'h1617);
        @(posedge clk);
        want <= 16'h0002;
        tick(4);
        chk("level flag", 32'(flag), 32'h2);
        chk("port1 level", 32'(lvl), 32'h6);
        @(posedge clk);
        clr <= 2'h2;
        @(posedge clk);
        clr <= 2'h0;
        want <= 16'h0003;
        tick(4);
        chk("clear ignored", 32'(flag), 32'h3);
        chk("port0 wins", 32'(vec), 32'h0);
        chk("port0 level", 32'(lvl), 32'h7);
        rdchk("status", 32'h00010FC0, 32'h00007013);
        @(posedge clk);
        want <= 16'h0000;
        tick(4);
        chk("level flag low", 32'(flag), 32'h0);
        $display("port test done");
    endtask : t_port
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_gate();
        t_port();
        complete_run();
    end
endmodule : tb_interrupt_enable_and_level_setup
